// ### logic/usc_defines.vh
`ifndef USC_DEFINES_VH
`define USC_DEFINES_VH
// Register byte offsets on the APB side
`define USC_OFS_DATA 5'h00
`define USC_OFS_STAT 5'h04
`define USC_OFS_CTLB 5'h08
`define USC_OFS_CTLC 5'h0c
`define USC_OFS_BAUDL 5'h10
`define USC_OFS_BAUDH 5'h14
// Control B field positions
`define USC_B_TXCIE 6
`define USC_B_UDRIE 5
`define USC_B_RXEN 4
`define USC_B_TXEN 3
`define USC_B_CSZ2 2
`define USC_B_TXB8 0
`define USC_B_WMASK 8'hfd
// Status field position that software may write
`define USC_A_TXC 6
// Control C fields
`define USC_C_MODE 7:6
`define USC_C_PAR 5:4
`define USC_C_STOP 3
`define USC_C_CSZ 2:1
`define USC_C_POL 0
// Reset values
`define USC_CTLB_RST 8'h00
`define USC_CTLC_RST 8'h06
`define USC_BAUD_RST 12'h000
// Operating modes
`define USC_MODE_ASYNC 2'h0
`define USC_MODE_SYNC 2'h1
`define USC_MODE_SPI 2'h3
// Receiver states
`define USC_RX_IDLE 2'h0
`define USC_RX_START 2'h1
`define USC_RX_DATA 2'h2
// Baud ticks per asynchronous bit, last index and midpoint
`define USC_TICK_LAST 4'hf
`define USC_TICK_MID 4'h7
`endif

// ### logic/usc_ctrl.v
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`include "usc_defines.vh"

module usc_ctrl (
    input wire pclk,
    input wire presetn,
    input wire [4:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    output wire [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire global_irq_enable,
    input wire tx_done_irq_ack,
    output wire tx_done_irq,
    output wire buffer_empty_irq,
    input wire serial_rx_pin,
    output wire serial_tx_pin,
    output wire tx_pin_override,
    output wire rx_pin_override,
    input wire port_tx_value,
    output wire sync_serial_clock,
    output wire sync_serial_clock_oe
);

    // Size code to data bits; reserved codes fall back to eight
    function [3:0] char_bits;
        input [2:0] code;
        begin
            case (code)
                3'h0: char_bits = 4'h5;
                3'h1: char_bits = 4'h6;
                3'h2: char_bits = 4'h7;
                3'h3: char_bits = 4'h8;
                3'h7: char_bits = 4'h9;
                default: char_bits = 4'h8;
            endcase
        end
    endfunction

    // Keep only the low n data bits
    function [8:0] mask_data;
        input [8:0] d;
        input [3:0] n;
        begin
            mask_data = d & ~(9'h1ff << n);
        end
    endfunction

    // Parity over the active data bits, odd inverts
    function par_calc;
        input [8:0] d;
        input [3:0] n;
        input odd;
        begin
            par_calc = (^mask_data(d, n)) ^ odd;
        end
    endfunction

    reg [7:0] ctl_b_q;
    reg [7:0] ctl_c_q;
    reg [11:0] baud_q;
    reg [11:0] baud_cnt_q;
    reg [31:0] prdata_q;
    reg xck_q;
    reg [8:0] tx_buf_q;
    reg tx_full_q;
    reg [12:0] tx_sh_q;
    reg [3:0] tx_left_q;
    reg [3:0] tx_div_q;
    reg tx_active_q;
    reg tx_done_q;
    reg tx_pin_q;
    reg rx_m_q;
    reg rx_s_q;
    reg [1:0] rx_st_q;
    reg [3:0] rx_cnt_q;
    reg [3:0] rx_left_q;
    reg [10:0] rx_sh_q;
    reg [8:0] rx_buf_q;
    reg rx_full_q;
    reg fe_q;
    reg dor_q;
    reg upe_q;
    reg [12:0] frame_d;
    reg [3:0] count_d;
    reg [10:0] rx_word_d;

    // Bus decode
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire addr_ok = (paddr == `USC_OFS_DATA) || (paddr == `USC_OFS_STAT) ||
                   (paddr == `USC_OFS_CTLB) || (paddr == `USC_OFS_CTLC) ||
                   (paddr == `USC_OFS_BAUDL) || (paddr == `USC_OFS_BAUDH);
    wire wr_data = wr & (paddr == `USC_OFS_DATA);
    wire rd_data = rd & (paddr == `USC_OFS_DATA);
    wire wr_baudl = wr & (paddr == `USC_OFS_BAUDL);

    // Decoded configuration
    wire [1:0] mode = ctl_c_q[`USC_C_MODE];
    wire sync_m = (mode == `USC_MODE_SYNC) | (mode == `USC_MODE_SPI);
    wire [1:0] par = ctl_c_q[`USC_C_PAR];
    wire par_on = par[1];
    wire par_odd = par[0];
    wire two_stop = ctl_c_q[`USC_C_STOP];
    wire pol = ctl_c_q[`USC_C_POL];
    wire [3:0] nbits = char_bits({ctl_b_q[`USC_B_CSZ2],
                                  ctl_c_q[`USC_C_CSZ]});
    wire rx_en = ctl_b_q[`USC_B_RXEN];

    // Baud tick and synchronous clock edges
    wire tick = (baud_cnt_q == 12'h000);
    wire rise_ev = sync_m & tick & ~xck_q;
    wire fall_ev = sync_m & tick & xck_q;
    wire tx_change = pol ? fall_ev : rise_ev;
    wire rx_sample = pol ? rise_ev : fall_ev;

    // Transmit sequencing
    wire tx_busy = (tx_left_q != 4'h0);
    wire tx_step = sync_m ? tx_change :
                   (tick & (tx_div_q == `USC_TICK_LAST));
    // Sync frames start on a change edge so the start bit is full length
    wire tx_load = tx_active_q & ~tx_busy & tx_full_q &
                   (~sync_m | tx_change);
    wire tx_last = tx_busy & tx_step & (tx_left_q == 4'h1);
    wire tx_done_clr = (wr & (paddr == `USC_OFS_STAT) &
                        pwdata[`USC_A_TXC]) | tx_done_irq_ack;

    // Receive sequencing
    wire rx_take = (rx_st_q == `USC_RX_DATA) &
                   (sync_m ? rx_sample :
                    (tick & (rx_cnt_q == `USC_TICK_LAST)));
    wire rx_last = rx_take & (rx_left_q == 4'h1);
    wire [3:0] rx_total = nbits + {3'h0, par_on} + 4'h1;
    wire rx_pop = rd_data & rx_full_q;

    // Frame image and length for the next transmission, and the aligned receive word
    always @*
    begin
        frame_d = (13'h1fff << (nbits + 4'h1)) |
                  ({4'h0, mask_data(tx_buf_q, nbits)} << 1);
        count_d = nbits + 4'h2 + {3'h0, two_stop};
        if (par_on)
        begin
            frame_d = (frame_d & ~(13'h0001 << (nbits + 4'h1))) |
                      ({12'h000, par_calc(tx_buf_q, nbits, par_odd)}
                       << (nbits + 4'h1));
            count_d = count_d + 4'h1;
        end
        rx_word_d = {rx_s_q, rx_sh_q[10:1]} >> (4'hb - rx_total);
    end

    // Register writes from the bus
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctl_b_q <= `USC_CTLB_RST;
            ctl_c_q <= `USC_CTLC_RST;
            baud_q <= `USC_BAUD_RST;
        end
        else if (wr)
        begin
            case (paddr)
                `USC_OFS_CTLB: ctl_b_q <= pwdata[7:0] & `USC_B_WMASK;
                `USC_OFS_CTLC: ctl_c_q <= pwdata[7:0];
                `USC_OFS_BAUDL: baud_q[7:0] <= pwdata[7:0];
                // Bits above eleven are not stored and read as zero
                `USC_OFS_BAUDH: baud_q[11:8] <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // Read data captured in the setup cycle so it comes from a flop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata_q <= 32'h00000000;
        else if (psel & ~penable)
        begin
            case (paddr)
                `USC_OFS_DATA: prdata_q <= {24'h000000, rx_buf_q[7:0]};
                `USC_OFS_STAT: prdata_q <= {24'h000000, rx_full_q,
                    tx_done_q, ~tx_full_q, fe_q, dor_q, upe_q, 2'h0};
                `USC_OFS_CTLB: prdata_q <= {24'h000000, ctl_b_q[7:2],
                    rx_buf_q[8], ctl_b_q[0]};
                `USC_OFS_CTLC: prdata_q <= {24'h000000, ctl_c_q};
                `USC_OFS_BAUDL: prdata_q <= {24'h000000, baud_q[7:0]};
                `USC_OFS_BAUDH: prdata_q <= {28'h0000000, baud_q[11:8]};
                default: prdata_q <= 32'h00000000;
            endcase
        end
    end

    // Prescaler; a low byte write restarts it with the new divisor
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            baud_cnt_q <= `USC_BAUD_RST;
            xck_q <= 1'b0;
        end
        else
        begin
            if (wr_baudl)
                baud_cnt_q <= {baud_q[11:8], pwdata[7:0]};
            else if (tick)
                baud_cnt_q <= baud_q;
            else
                baud_cnt_q <= baud_cnt_q - 12'h001;
            // Master clock toggles per tick, parked low outside sync
            if (!sync_m)
                xck_q <= 1'b0;
            else if (tick)
                xck_q <= ~xck_q;
        end
    end

    // Transmit buffer, shifter and deferred disable
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tx_buf_q <= 9'h000;
            tx_full_q <= 1'b0;
            tx_sh_q <= 13'h1fff;
            tx_left_q <= 4'h0;
            tx_div_q <= 4'h0;
            tx_active_q <= 1'b0;
            tx_done_q <= 1'b0;
            tx_pin_q <= 1'b1;
        end
        else
        begin
            // Writes while the buffer is occupied are dropped
            if (wr_data & ~tx_full_q)
            begin
                tx_buf_q <= {ctl_b_q[`USC_B_TXB8], pwdata[7:0]};
                tx_full_q <= 1'b1;
            end
            else if (tx_load)
                tx_full_q <= 1'b0;
            if (tx_load)
            begin
                tx_sh_q <= frame_d;
                tx_left_q <= count_d;
                tx_div_q <= 4'h0;
            end
            else if (tx_busy & tx_step)
            begin
                tx_sh_q <= {1'b1, tx_sh_q[12:1]};
                tx_left_q <= tx_left_q - 4'h1;
                tx_div_q <= 4'h0;
            end
            else if (tx_busy & tick)
                tx_div_q <= tx_div_q + 4'h1;
            // Stays on while anything is still queued
            tx_active_q <= ctl_b_q[`USC_B_TXEN] |
                           (tx_active_q & (tx_busy | tx_full_q));
            // A completing frame wins over a clear in the same cycle
            if (tx_last & ~tx_full_q)
                tx_done_q <= 1'b1;
            else if (tx_done_clr)
                tx_done_q <= 1'b0;
            // Pin moves on the shift edge itself, not one clock later
            if (!tx_active_q)
                tx_pin_q <= port_tx_value;
            else if (tx_load)
                tx_pin_q <= frame_d[0];
            else if (tx_busy & tx_step)
                tx_pin_q <= tx_sh_q[1];
            else if (!tx_busy)
                tx_pin_q <= 1'b1;
        end
    end

    // Receive pin synchroniser
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
        end
        else
        begin
            rx_m_q <= serial_rx_pin;
            rx_s_q <= rx_m_q;
        end
    end

    // Receive framing: start check, then one sample per bit
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_st_q <= `USC_RX_IDLE;
            rx_cnt_q <= 4'h0;
            rx_left_q <= 4'h0;
            rx_sh_q <= 11'h000;
        end
        else if (!rx_en)
            rx_st_q <= `USC_RX_IDLE;
        else
        begin
            if (tick)
                rx_cnt_q <= rx_cnt_q + 4'h1;
            case (rx_st_q)
                `USC_RX_IDLE:
                begin
                    rx_left_q <= rx_total;
                    rx_cnt_q <= 4'h0;
                    if (sync_m ? (rx_sample & ~rx_s_q) : (tick & ~rx_s_q))
                        rx_st_q <= sync_m ? `USC_RX_DATA : `USC_RX_START;
                end
                `USC_RX_START:
                begin
                    // Mid-bit recheck rejects short glitches
                    if (tick & (rx_cnt_q == `USC_TICK_MID))
                    begin
                        rx_cnt_q <= 4'h0;
                        rx_st_q <= rx_s_q ? `USC_RX_IDLE : `USC_RX_DATA;
                    end
                end
                `USC_RX_DATA:
                begin
                    if (rx_take)
                    begin
                        rx_sh_q <= {rx_s_q, rx_sh_q[10:1]};
                        rx_left_q <= rx_left_q - 4'h1;
                        rx_cnt_q <= 4'h0;
                        if (rx_last)
                            rx_st_q <= `USC_RX_IDLE;
                    end
                end
                default: rx_st_q <= `USC_RX_IDLE;
            endcase
        end
    end

    // Receive buffer with its error flags; a new frame beats a pop
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rx_buf_q <= 9'h000;
            rx_full_q <= 1'b0;
            fe_q <= 1'b0;
            dor_q <= 1'b0;
            upe_q <= 1'b0;
        end
        else if (!rx_en)
        begin
            rx_buf_q <= 9'h000;
            rx_full_q <= 1'b0;
            fe_q <= 1'b0;
            dor_q <= 1'b0;
            upe_q <= 1'b0;
        end
        else if (rx_last & rx_full_q & ~rx_pop)
            dor_q <= 1'b1; // Unread data kept, new frame lost
        else if (rx_last)
        begin
            rx_buf_q <= mask_data(rx_word_d[8:0], nbits);
            rx_full_q <= 1'b1;
            fe_q <= ~rx_word_d[nbits + {3'h0, par_on}];
            dor_q <= 1'b0;
            upe_q <= par_on & (rx_word_d[nbits] !=
                     par_calc(rx_word_d[8:0], nbits, par_odd));
        end
        else if (rx_pop)
        begin
            // Ninth bit stays readable; only the flags go
            rx_full_q <= 1'b0;
            fe_q <= 1'b0;
            dor_q <= 1'b0;
            upe_q <= 1'b0;
        end
    end

    // Bus answers: zero wait states, error on unmapped offsets
    assign pready = 1'b1;
    assign pslverr = acc & ~addr_ok;
    assign prdata = prdata_q;

    // Interrupt requests gated by the global enable
    assign tx_done_irq = ctl_b_q[`USC_B_TXCIE] & global_irq_enable &
                         tx_done_q;
    assign buffer_empty_irq = ctl_b_q[`USC_B_UDRIE] & global_irq_enable &
                              ~tx_full_q;

    // Pin ownership
    assign serial_tx_pin = tx_pin_q;
    assign tx_pin_override = tx_active_q;
    assign rx_pin_override = rx_en;
    assign sync_serial_clock = xck_q;
    assign sync_serial_clock_oe = sync_m & (tx_active_q | rx_en);

endmodule

// ### sim/usc_ctrl_sva.sv
`timescale 1ns/1ps
`include "usc_defines.vh"

module usc_ctrl_sva (
    input wire pclk,
    input wire presetn,
    input wire [4:0] paddr,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [31:0] pwdata,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire global_irq_enable,
    input wire tx_done_irq_ack,
    input wire tx_done_irq,
    input wire buffer_empty_irq,
    input wire serial_rx_pin,
    input wire serial_tx_pin,
    input wire tx_pin_override,
    input wire rx_pin_override,
    input wire port_tx_value,
    input wire sync_serial_clock,
    input wire sync_serial_clock_oe
);
    reg [7:0] ctlb_q;
    reg [7:0] ctlc_q;
    wire wr_acc;
    wire rd_acc;

    // Bus phase decode shared by the shadows and the read checks
    assign wr_acc = psel && penable && pready && pwrite;
    assign rd_acc = psel && penable && !pwrite;

    // Shadow copies, so gating can be judged without peeking inside
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctlb_q <= `USC_CTLB_RST;
            ctlc_q <= `USC_CTLC_RST;
        end
        else if (wr_acc && paddr == `USC_OFS_CTLB)
            ctlb_q <= pwdata[7:0];
        else if (wr_acc && paddr == `USC_OFS_CTLC)
            ctlc_q <= pwdata[7:0];
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_txdone_irq_gate: assert property (
        tx_done_irq |-> global_irq_enable && ctlb_q[6])
        else $error("tx done irq without its enables");
    a_empty_irq_gate: assert property (
        buffer_empty_irq |-> global_irq_enable && ctlb_q[5])
        else $error("buffer empty irq without its enables");
    a_rx_pin_own: assert property (
        rx_pin_override == ctlb_q[4])
        else $error("rx override differs from enable");
    a_tx_pin_take: assert property (
        wr_acc && paddr == `USC_OFS_CTLB && pwdata[3] |-> ##2 tx_pin_override)
        else $error("tx override not taken");
    a_tx_port_pass: assert property (
        $past(presetn) && !$past(tx_pin_override)
        |-> serial_tx_pin == $past(port_tx_value))
        else $error("port value not on tx pin");
    a_tx_release_idle: assert property (
        $fell(tx_pin_override) |-> !ctlb_q[3] && $past(serial_tx_pin))
        else $error("tx released mid frame");
    a_async_clk_off: assert property (
        ctlc_q[7:6] == `USC_MODE_ASYNC &&
        $past(ctlc_q[7:6]) == `USC_MODE_ASYNC
        |-> !sync_serial_clock && !sync_serial_clock_oe)
        else $error("sync clock active in async mode");
    a_ctlc_readback: assert property (
        rd_acc && paddr == `USC_OFS_CTLC |-> prdata == {24'h0, ctlc_q})
        else $error("control c readback wrong");
    a_baud_high_zero: assert property (
        rd_acc && paddr == `USC_OFS_BAUDH |-> prdata[31:4] == 28'h0)
        else $error("divisor high reads extra bits");

    cover property ($rose(tx_done_irq));
    cover property ($fell(tx_pin_override));
    cover property (buffer_empty_irq);
endmodule

// ### sim/usc_remote.sv
`timescale 1ns/1ps

// Far station: idle-high line, LSB first, one start bit
module usc_remote (
    input wire pclk,
    input wire serial_tx_pin,
    output logic serial_rx_pin
);
    int bit_len = 16;

    initial serial_rx_pin = 1'b1;

    // Sends start, then n given bits; one stop is enough here
    task send(input logic [12:0] f, input int n);
        int k;
        @(posedge pclk);
        serial_rx_pin <= 1'b0;
        repeat (bit_len) @(posedge pclk);
        for (k = 0; k < n; k++)
        begin
            serial_rx_pin <= f[k];
            repeat (bit_len) @(posedge pclk);
        end
        serial_rx_pin <= 1'b1;
    endtask

    // Mid-bit sampling, so a wrong bit rate shows as bad data
    task recv(input int n, output logic [12:0] f);
        int k;
        f = '1;
        while (serial_tx_pin !== 1'b0) @(posedge pclk);
        repeat (bit_len / 2) @(posedge pclk);
        for (k = 0; k < n; k++)
        begin
            repeat (bit_len) @(posedge pclk);
            f[k] = serial_tx_pin;
        end
    endtask
endmodule

// ### sim/usart_control_and_baud_config_test.sv
`timescale 1ns/1ps
`include "usc_defines.vh"

module usart_control_and_baud_config_test;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [4:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic gie, ack, tx_irq, be_irq, rxd, txd, tx_own, rx_own, port_val;
    logic last_err, xck, xck_oe;
    int err_count, check_count, i, cnt;
    logic [12:0] f, got;

    usc_ctrl i_usc_ctrl (.pclk(pclk), .presetn(presetn), .paddr(paddr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .global_irq_enable(gie), .tx_done_irq_ack(ack),
        .tx_done_irq(tx_irq), .buffer_empty_irq(be_irq),
        .serial_rx_pin(rxd), .serial_tx_pin(txd),
        .tx_pin_override(tx_own), .rx_pin_override(rx_own),
        .port_tx_value(port_val), .sync_serial_clock(xck),
        .sync_serial_clock_oe(xck_oe));
    usc_remote i_usc_remote (.pclk(pclk), .serial_tx_pin(txd),
        .serial_rx_pin(rxd));

    task end_sim;
        $display("checks %0d errors %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got_v, input logic [31:0] exp_v);
        check_count++;
        if (got_v !== exp_v)
        begin
            err_count++;
            $display("CHECK FAILED %0t: got %h exp %h", $time, got_v, exp_v);
        end
    endtask

    // One APB transfer; request held until pready seen at an edge
    task xfer(input logic w, input logic [4:0] a, input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        q = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Expected line bits after start: data, parity, stop ones
    function automatic logic [12:0] mkf(input logic [8:0] d, input int n,
        input logic [1:0] par, input logic s2, output int c);
        logic [12:0] r;
        r = '1;
        for (int k = 0; k < n; k++)
            r[k] = d[k];
        c = n + 1 + s2;
        if (par[1])
        begin
            r[n] = ^(d & ((9'h1 << n) - 9'h1)) ^ par[0];
            c++;
        end
        return r;
    endfunction

    // Ninth bit goes in before the data byte; polarity kept 0
    task s_tx(input logic [7:0] c, input logic z2, input logic [8:0] d);
        f = mkf(d, z2 ? 9 : 5 + c[2:1], c[5:4], c[3], cnt);
        xfer(1, `USC_OFS_CTLC, c);
        xfer(1, `USC_OFS_CTLB, {5'h01, z2, 1'b0, d[8]});
        fork
            i_usc_remote.recv(cnt, got);
            xfer(1, `USC_OFS_DATA, d[7:0]);
        join
        chk(got, f);
        repeat (i_usc_remote.bit_len + 4) @(posedge pclk);
    endtask

    task s_reset;
        xfer(0, `USC_OFS_CTLC, 8'h0);
        chk(q, 32'h06);
        xfer(0, `USC_OFS_STAT, 8'h0);
        chk(q, 32'h20);
        xfer(0, 5'h18, 8'h0);
        chk(last_err, 1);
        xfer(1, `USC_OFS_BAUDH, 8'h0a);
        xfer(0, `USC_OFS_BAUDH, 8'h0);
        chk(q, 32'h0a);
        xfer(1, `USC_OFS_BAUDH, 8'h00);
        xfer(1, `USC_OFS_BAUDL, 8'h00);
    endtask

    task s_irq;
        xfer(1, `USC_OFS_CTLB, 8'h20);
        @(negedge pclk);
        chk(be_irq, 0);
        @(posedge pclk);
        gie <= 1'b1;
        @(negedge pclk);
        chk(be_irq, 1);
    endtask

    // Disable written mid frame must wait for the frame to end
    task s_done;
        fork
            i_usc_remote.recv(10, got);
            begin
                xfer(1, `USC_OFS_CTLB, 8'h48);
                xfer(1, `USC_OFS_DATA, 8'ha5);
                xfer(1, `USC_OFS_CTLB, 8'h40);
                @(negedge pclk);
                chk(tx_own, 1);
            end
        join
        chk(got, 13'h1fa5);
        for (i = 0; i < 64 && tx_irq !== 1'b1; i++) @(negedge pclk);
        chk(tx_irq, 1);
        chk(tx_own, 0);
        @(posedge pclk);
        gie <= 1'b0;
        @(negedge pclk);
        chk(tx_irq, 0);
        @(posedge pclk);
        gie <= 1'b1;
        ack <= 1'b1;
        @(posedge pclk);
        ack <= 1'b0;
        port_val <= 1'b0;
        repeat (3) @(negedge pclk);
        chk(tx_irq, 0);
        chk(txd, 0);
        @(posedge pclk);
        port_val <= 1'b1;
    endtask

    // Sync mode, polarity 0: bits taken at falling clock edges
    task s_sync;
        xfer(1, `USC_OFS_CTLC, 8'h46);
        xfer(1, `USC_OFS_CTLB, 8'h08);
        got = 13'h1fff;
        cnt = 0;
        fork
            xfer(1, `USC_OFS_DATA, 8'h5a);
            while (cnt < 10)
            begin
                @(posedge pclk);
                // Pre-edge values: a high clock falls at this edge
                if (xck === 1'b1 && (cnt > 0 || txd === 1'b0))
                begin
                    got[cnt] = txd;
                    cnt++;
                end
            end
        join
        chk(got, 13'h1eb4);
        chk(xck_oe, 1);
        repeat (8) @(posedge pclk);
    endtask

    task s_rx;
        xfer(1, `USC_OFS_CTLC, 8'h36);
        xfer(1, `USC_OFS_CTLB, 8'h14);
        @(negedge pclk);
        chk(rx_own, 1);
        f = mkf(9'h1c6, 9, 2'b11, 1'b0, cnt);
        i_usc_remote.send(f, cnt);
        repeat (20) @(posedge pclk);
        xfer(0, `USC_OFS_CTLB, 8'h0);
        chk(q[1], 1);
        xfer(0, `USC_OFS_DATA, 8'h0);
        chk(q, 32'hc6);
        xfer(0, `USC_OFS_STAT, 8'h0);
        chk(q[2], 0);
        i_usc_remote.send(f ^ 13'h200, cnt);
        repeat (20) @(posedge pclk);
        xfer(0, `USC_OFS_STAT, 8'h0);
        chk(q & 32'h84, 32'h84);
        xfer(1, `USC_OFS_CTLB, 8'h04);
        xfer(0, `USC_OFS_STAT, 8'h0);
        chk(q & 32'h9c, 0);
        chk(rx_own, 0);
    endtask

    initial
    begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    initial
    begin
        #80000;
        err_count++;
        end_sim;
    end

    initial
    begin
        {presetn, psel, penable, pwrite, gie, ack} = 6'h0;
        paddr = 5'h0;
        pwdata = 32'h0;
        port_val = 1'b1;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        s_reset;
        s_irq;
        s_done;
        s_tx(8'h06, 1'b0, 9'h055);
        s_tx(8'h2c, 1'b0, 9'h03a);
        s_tx(8'h36, 1'b1, 9'h1c3);
        s_tx(8'h00, 1'b0, 9'h013);
        xfer(1, `USC_OFS_BAUDL, 8'h01);
        i_usc_remote.bit_len = 32;
        s_tx(8'h06, 1'b0, 9'h0f0);
        xfer(1, `USC_OFS_BAUDL, 8'h00);
        i_usc_remote.bit_len = 16;
        s_sync;
        s_rx;
        end_sim;
    end
endmodule

bind usc_ctrl usc_ctrl_sva i_usc_ctrl_sva (.pclk(pclk), .presetn(presetn),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .global_irq_enable(global_irq_enable),
    .tx_done_irq_ack(tx_done_irq_ack), .tx_done_irq(tx_done_irq),
    .buffer_empty_irq(buffer_empty_irq), .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin), .tx_pin_override(tx_pin_override),
    .rx_pin_override(rx_pin_override), .port_tx_value(port_tx_value),
    .sync_serial_clock(sync_serial_clock),
    .sync_serial_clock_oe(sync_serial_clock_oe));
